//--- rtl/awce_regs.vh
// Purpose: Constants for the task-file write command engine.
// Assumes: Register indices are word indices on the Avalon-MM slave.
// Notes: Definitions only.
`ifndef AWCE_REGS_VH
`define AWCE_REGS_VH
// ==========================================================
// Register indices
`define AWCE_IDX_DATA 4'h0
`define AWCE_IDX_FEAT 4'h1
`define AWCE_IDX_CNT 4'h2
`define AWCE_IDX_SNUM 4'h3
`define AWCE_IDX_CLO 4'h4
`define AWCE_IDX_CHI 4'h5
`define AWCE_IDX_DRVHD 4'h6
`define AWCE_IDX_CMD 4'h7
`define AWCE_IDX_BLKCTL 4'h8
// ==========================================================
// Opcodes
`define AWCE_OP_WRSEC_A 8'h30
`define AWCE_OP_WRSEC_B 8'h31
`define AWCE_OP_WRSEC_NOER 8'h38
`define AWCE_OP_WRVERIFY 8'h3C
`define AWCE_OP_WRLONG_A 8'h32
`define AWCE_OP_WRLONG_B 8'h33
`define AWCE_OP_WRLONG_C 8'h23
`define AWCE_OP_WRBLK 8'hC5
`define AWCE_OP_WRBLK_NOER 8'hCD
`define AWCE_OP_SETBLK 8'hC6
// ==========================================================
// Field positions
`define AWCE_ST_BSY 7
`define AWCE_ST_DRDY 6
`define AWCE_ST_DSC 4
`define AWCE_ST_DRQ 3
`define AWCE_ST_ERR 0
`define AWCE_ER_IDNF 4
`define AWCE_ER_ABRT 2
`define AWCE_DH_LBA 6
// ==========================================================
// Sizes, geometry and reset values
`define AWCE_SECT_WORDS 9'h100
`define AWCE_LONG_WORDS 9'h102
`define AWCE_MAX_BLK 5'h10
`define AWCE_SPT 8'h3F
`define AWCE_LAST_HEAD 4'hF
`define AWCE_RST_TF 8'h00
`define AWCE_RST_CNT 8'h01
`define AWCE_RST_DRVHD 8'hA0
// ==========================================================
// Timing
`define AWCE_CLK_NS 4
`define AWCE_BSY_NS 400
`define AWCE_BSY_CYC (`AWCE_BSY_NS / `AWCE_CLK_NS)
`endif

//--- rtl/awce_write_engine.v
// Purpose: Device-side write command engine behind an ATA-style task file.
// Assumes: Avalon-MM slave, word indexed; flash back end on the same clock.
// Notes: One sector buffer; back end programs a sector per progStart.
`timescale 1ns/1ps
`default_nettype none
`include "awce_regs.vh"

module awce_write_engine (
  input wire clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg intrq,
  output reg progStart,
  output reg [27:0] progAddr,
  output reg progErase,
  output reg progVerify,
  input wire progDone,
  input wire progErr,
  input wire [7:0] bufRdAddr,
  output reg [15:0] bufRdData
);

  // ==========================================================
  // States
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SETUP = 3'd1;
  localparam [2:0] ST_XFER = 3'd2;
  localparam [2:0] ST_PROG = 3'd3;
  localparam [2:0] ST_FIN = 3'd4;

  reg [2:0] state_reg;
  reg [7:0] feat_reg;
  reg [7:0] cnt_reg;
  reg [7:0] snum_reg;
  reg [7:0] clo_reg;
  reg [7:0] chi_reg;
  reg [7:0] drvhd_reg;
  reg [7:0] errCode_reg;
  reg bsy_reg;
  reg drq_reg;
  reg errFlag_reg;
  reg irqPulse_reg;
  reg multEn_reg;
  reg [4:0] multSz_reg;
  reg [4:0] blkSz_reg;
  reg [4:0] blkLeft_reg;
  reg [8:0] rem_reg;
  reg [8:0] wordCnt_reg;
  reg [8:0] wordLast_reg;
  // One sector deep: each sector is programmed before the next fill
  reg [15:0] secBuf [0:255];

  // ==========================================================
  // Bus decode
  wire busReq = avs_read | avs_write;
  wire wrDone = avs_write & ~avs_waitrequest;
  wire rdDone = avs_read & ~avs_waitrequest;
  wire tfWr = wrDone & ~bsy_reg;
  wire cmdWr = tfWr & (avs_address == `AWCE_IDX_CMD);
  wire isData = (avs_address == `AWCE_IDX_DATA);
  wire dataWr = wrDone & isData & drq_reg & (state_reg == ST_XFER);
  wire [7:0] opc = avs_writedata[7:0];
  // Mid-block programming keeps DRQ up, so data writes stall instead
  wire dataStall = avs_write & isData & (state_reg == ST_PROG);
  wire [7:0] statusByte = {bsy_reg, ~bsy_reg, 1'b0, 1'b1, drq_reg, 2'b00, errFlag_reg};
  wire [8:0] cntAsRem = (cnt_reg == 8'h00) ? 9'h100 : {1'b0, cnt_reg};
  wire [8:0] remDec = rem_reg - 9'h001;

  // ==========================================================
  // Addressing
  wire lbaMode = drvhd_reg[`AWCE_DH_LBA];
  wire [27:0] lbaCur = {drvhd_reg[3:0], chi_reg, clo_reg, snum_reg};
  // Geometry is fixed; both modes end in one linear program address
  wire [27:0] cylHead = {8'h00, chi_reg, clo_reg, drvhd_reg[3:0]};
  wire [27:0] chsLin = (cylHead * {20'h00000, `AWCE_SPT}) + {20'h00000, snum_reg}
                       - 28'h0000001;
  wire [27:0] lbaInc = lbaCur + 28'h0000001;
  // Sector wraps to 1, then head, then cylinder
  wire secWrap = (snum_reg == `AWCE_SPT);
  wire headWrap = (drvhd_reg[3:0] == `AWCE_LAST_HEAD);
  wire [15:0] cylInc = {chi_reg, clo_reg} + 16'h0001;

  // Sectors in the next block: a full block or the remainder
  function [4:0] blkFill;
    input [4:0] sz;
    input [8:0] r;
    begin
      if (r < {4'h0, sz}) begin
        blkFill = r[4:0];
      end else begin
        blkFill = sz;
      end
    end
  endfunction

  // ==========================================================
  // Avalon handshake: one wait cycle per access, except data writes in ST_PROG, which stall until programming ends
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else if (busReq & avs_waitrequest & ~dataStall) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Loaded in the wait cycle, so it stands at the completing edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & avs_waitrequest) begin
      case (avs_address)
        `AWCE_IDX_FEAT: avs_readdata <= {24'h000000, errCode_reg};
        `AWCE_IDX_CNT: avs_readdata <= {24'h000000, cnt_reg};
        `AWCE_IDX_SNUM: avs_readdata <= {24'h000000, snum_reg};
        `AWCE_IDX_CLO: avs_readdata <= {24'h000000, clo_reg};
        `AWCE_IDX_CHI: avs_readdata <= {24'h000000, chi_reg};
        `AWCE_IDX_DRVHD: avs_readdata <= {24'h000000, drvhd_reg};
        `AWCE_IDX_CMD: avs_readdata <= {24'h000000, statusByte};
        `AWCE_IDX_BLKCTL: avs_readdata <= {26'h0000000, multEn_reg, multSz_reg};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Interrupt line: cleared by a status read, a new event wins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intrq <= 1'b0;
    end else if (irqPulse_reg) begin
      intrq <= 1'b1;
    end else if (rdDone & (avs_address == `AWCE_IDX_CMD)) begin
      intrq <= 1'b0;
    end else if (cmdWr & (state_reg == ST_IDLE)) begin
      // A new command drops a stale interrupt
      intrq <= 1'b0;
    end
  end

  // ==========================================================
  // Sector buffer
  // Long-write extras land past word 255 and are never stored
  always @(posedge clk) begin
    if (dataWr & ~wordCnt_reg[8]) begin
      secBuf[wordCnt_reg[7:0]] <= avs_writedata[15:0];
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bufRdData <= 16'h0000;
    end else begin
      bufRdData <= secBuf[bufRdAddr];
    end
  end

  // ==========================================================
  // Command engine and task file
  // Task-file writes are ignored while busy
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      feat_reg <= `AWCE_RST_TF;
      cnt_reg <= `AWCE_RST_CNT;
      snum_reg <= `AWCE_RST_CNT;
      clo_reg <= `AWCE_RST_TF;
      chi_reg <= `AWCE_RST_TF;
      drvhd_reg <= `AWCE_RST_DRVHD;
      errCode_reg <= `AWCE_RST_TF;
      bsy_reg <= 1'b0;
      drq_reg <= 1'b0;
      errFlag_reg <= 1'b0;
      irqPulse_reg <= 1'b0;
      multEn_reg <= 1'b0;
      multSz_reg <= 5'h00;
      blkSz_reg <= 5'h01;
      blkLeft_reg <= 5'h00;
      rem_reg <= 9'h000;
      wordCnt_reg <= 9'h000;
      wordLast_reg <= `AWCE_SECT_WORDS;
      progStart <= 1'b0;
      progAddr <= 28'h0000000;
      progErase <= 1'b0;
      progVerify <= 1'b0;
    end else begin
      progStart <= 1'b0;
      irqPulse_reg <= 1'b0;
      if (tfWr) begin
        case (avs_address)
          `AWCE_IDX_FEAT: feat_reg <= opc;
          `AWCE_IDX_CNT: cnt_reg <= opc;
          `AWCE_IDX_SNUM: snum_reg <= opc;
          `AWCE_IDX_CLO: clo_reg <= opc;
          `AWCE_IDX_CHI: chi_reg <= opc;
          `AWCE_IDX_DRVHD: drvhd_reg <= opc;
          default: ;
        endcase
      end
      if (dataWr) begin
        wordCnt_reg <= wordCnt_reg + 9'h001;
      end
      case (state_reg)
        ST_IDLE: begin
          if (cmdWr) begin
            // Busy from the accepting edge on
            bsy_reg <= 1'b1;
            errFlag_reg <= 1'b0;
            errCode_reg <= 8'h00;
            blkSz_reg <= 5'h01;
            wordLast_reg <= `AWCE_SECT_WORDS;
            rem_reg <= cntAsRem;
            progErase <= 1'b1;
            progVerify <= 1'b0;
            state_reg <= ST_SETUP;
            case (opc)
              `AWCE_OP_WRSEC_A, `AWCE_OP_WRSEC_B: ;
              `AWCE_OP_WRSEC_NOER: begin
                progErase <= 1'b0;
              end
              `AWCE_OP_WRVERIFY: begin
                progVerify <= 1'b1;
              end
              `AWCE_OP_WRLONG_A, `AWCE_OP_WRLONG_B, `AWCE_OP_WRLONG_C: begin
                rem_reg <= 9'h001;
                wordLast_reg <= `AWCE_LONG_WORDS;
              end
              `AWCE_OP_WRBLK, `AWCE_OP_WRBLK_NOER: begin
                progErase <= (opc == `AWCE_OP_WRBLK);
                blkSz_reg <= multSz_reg;
                if (!multEn_reg) begin
                  errFlag_reg <= 1'b1;
                  errCode_reg[`AWCE_ER_ABRT] <= 1'b1;
                  state_reg <= ST_FIN;
                end
              end
              `AWCE_OP_SETBLK: begin
                state_reg <= ST_FIN;
                // Size kept even when refused; only the enable gates block writes
                multSz_reg <= cnt_reg[4:0];
                if (cnt_reg == 8'h00) begin
                  multEn_reg <= 1'b0;
                end else if ((cnt_reg[4:0] <= `AWCE_MAX_BLK) & (cnt_reg[7:5] == 3'h0)
                             & ((cnt_reg[4:0] & (cnt_reg[4:0] - 5'h01)) == 5'h00)) begin
                  multEn_reg <= 1'b1;
                end else begin
                  multEn_reg <= 1'b0;
                  errFlag_reg <= 1'b1;
                  errCode_reg[`AWCE_ER_ABRT] <= 1'b1;
                end
              end
              default: begin
                errFlag_reg <= 1'b1;
                errCode_reg[`AWCE_ER_ABRT] <= 1'b1;
                state_reg <= ST_FIN;
              end
            endcase
          end
        end
        ST_SETUP: begin
          // First fill opens quietly
          bsy_reg <= 1'b0;
          drq_reg <= 1'b1;
          wordCnt_reg <= 9'h000;
          blkLeft_reg <= blkFill(blkSz_reg, rem_reg);
          state_reg <= ST_XFER;
        end
        ST_XFER: begin
          // Last word of a block leaves busy set until programmed
          if (dataWr & (wordCnt_reg == wordLast_reg - 9'h001)) begin
            progStart <= 1'b1;
            progAddr <= lbaMode ? lbaCur : chsLin;
            state_reg <= ST_PROG;
            if (blkLeft_reg == 5'h01) begin
              bsy_reg <= 1'b1;
              drq_reg <= 1'b0;
            end
          end
        end
        ST_PROG: begin
          if (progDone) begin
            if (progErr) begin
              // Address stays on failing sector
              drq_reg <= 1'b0;
              bsy_reg <= 1'b0;
              errFlag_reg <= 1'b1;
              errCode_reg[`AWCE_ER_IDNF] <= 1'b1;
              cnt_reg <= rem_reg[7:0];
              irqPulse_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              rem_reg <= remDec;
              cnt_reg <= remDec[7:0];
              wordCnt_reg <= 9'h000;
              if (lbaMode) begin
                snum_reg <= lbaInc[7:0];
                clo_reg <= lbaInc[15:8];
                chi_reg <= lbaInc[23:16];
                drvhd_reg[3:0] <= lbaInc[27:24];
              end else if (!secWrap) begin
                snum_reg <= snum_reg + 8'h01;
              end else begin
                snum_reg <= 8'h01;
                drvhd_reg[3:0] <= drvhd_reg[3:0] + 4'h1;
                if (headWrap) begin
                  clo_reg <= cylInc[7:0];
                  chi_reg <= cylInc[15:8];
                end
              end
              if (rem_reg == 9'h001) begin
                bsy_reg <= 1'b0;
                drq_reg <= 1'b0;
                irqPulse_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end else if (blkLeft_reg == 5'h01) begin
                bsy_reg <= 1'b0;
                drq_reg <= 1'b1;
                irqPulse_reg <= 1'b1;
                blkLeft_reg <= blkFill(blkSz_reg, remDec);
                state_reg <= ST_XFER;
              end else begin
                // Inside a block: no interrupt, DRQ already up
                blkLeft_reg <= blkLeft_reg - 5'h01;
                state_reg <= ST_XFER;
              end
            end
          end
        end
        ST_FIN: begin
          bsy_reg <= 1'b0;
          irqPulse_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- tb/ata_write_command_engine_tb_top.sv
// Purpose: Self-checking bench for the write engine.
// Assumes: Word-indexed Avalon slave, back end from the flash model.
// Notes: Word i of sector s is {s, i}; long-write extras are EEEE.
`timescale 1ns/1ps
`default_nettype none
module ata_write_command_engine_tb_top;
  localparam logic [31:0] LBA_TF = 32'hE5302010;
  localparam logic [27:0] LBA = 28'h5302010;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest, intrq, progStart;
  logic progErase, progVerify, progDone, progErr;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [27:0] progAddr, failAddr;
  logic [7:0] bufRdAddr, lat;
  logic [15:0] bufRdData, lastWord;
  int nStarts, badCount, nChecks, i;
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'hA0, 8'h50, 8'h00, 8'h00};
  logic [7:0] ops [7] = '{8'h30, 8'h31, 8'h38, 8'h3C, 8'h33, 8'h32, 8'h23};
  logic [1:0] evs [7] = '{2'h2, 2'h2, 2'h0, 2'h3, 2'h2, 2'h2, 2'h2};
  logic [7:0] nop [6] = '{8'hC5, 8'hCD, 8'hC6, 8'hC6, 8'hC6, 8'hC6};
  logic [7:0] ncn [6] = '{8'h02, 8'h02, 8'h03, 8'h10, 8'h00, 8'h04};
  logic [7:0] nbk [6] = '{8'h00, 8'h00, 8'h03, 8'h30, 8'h00, 8'h24};
  awce_write_engine u_dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .intrq, .progStart, .progAddr, .progErase, .progVerify,
    .progDone, .progErr, .bufRdAddr, .bufRdData);
  awce_flash_model u_flash (.clk, .rstn, .progStart, .progAddr, .bufRdData, .failAddr, .lat,
    .bufRdAddr, .progDone, .progErr, .lastWord, .nStarts);
  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Release costs an idle cycle so no signal is driven twice per step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic waitIrq(input logic must);
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (must) chk({31'h0, intrq}, 32'h1);
  endtask
  task automatic xfer(input logic [7:0] op, input logic [7:0] cnt, input int nsec, blk, wds,
      input logic [31:0] tf, input logic [27:0] base, input int fs, input logic [1:0] ev);
    logic [31:0] q;
    int s0, k, s;
    s0 = nStarts;
    for (k = 0; k < 4; k++) wr(4'h6 - k[3:0], {24'h0, tf[31 - 8 * k -: 8]});
    wr(4'h2, {24'h0, cnt});
    wr(4'h7, {24'h0, op});
    k = 0;
    do begin
      bus(1'b0, 4'h7, 32'h0, q);
      k++;
    end while (q[7] !== 1'b0 && k < 50);
    chk(q, 32'h58);
    for (s = 0; s < nsec; s++) begin
      if (s > 0 && s % blk == 0) begin
        waitIrq(1'b1);
        rdc(4'h7, 32'h58);
      end
      for (k = 0; k < wds; k++) wr(4'h0, k < 256 ? {16'h0, s[7:0], k[7:0]} : 32'hEEEE);
      chk({31'h0, intrq}, 32'h0);
      rdc(4'h7, ((s + 1) % blk == 0 || s + 1 == nsec) ? 32'h90 : 32'h58);
      chk({4'h0, progAddr}, {4'h0, base + s[27:0]});
      chk({30'h0, progErase, progVerify}, {30'h0, ev});
      if (s == fs) break;
    end
    k = fs < nsec ? fs : nsec - 1;
    waitIrq(1'b1);
    rdc(4'h7, fs < nsec ? 32'h51 : 32'h50);
    rdc(4'h1, fs < nsec ? 32'h10 : 32'h00);
    rdc(4'h2, fs < nsec ? {24'h0, cnt - fs[7:0]} : 32'h0);
    if (fs < nsec) rdc(4'h3, {24'h0, base[7:0] + k[7:0]});
    chk(nStarts - s0, k + 1);
    chk({16'h0, lastWord}, {16'h0, k[7:0], 8'hFF});
  endtask
  // ==========================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #320000;
    badCount++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    failAddr = 28'hFFFFFFF;
    lat = 8'h03;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 10; i++) rdc(i[3:0], {24'h0, rv[i]});
    for (i = 0; i < 7; i++)
      xfer(ops[i], 8'h02, i < 4 ? 2 : 1, 1, i < 4 ? 256 : 258, LBA_TF, LBA, 99, evs[i]);
    xfer(8'h30, 8'h01, 1, 1, 256, 32'hA3000205, 28'h00008A1, 99, 2'h2);
    xfer(8'h30, 8'h02, 2, 1, 256, 32'hAF00023F, 28'h0000BCF, 99, 2'h2);
    lat <= 8'h3C;
    for (i = 0; i < 6; i++) begin
      wr(4'h2, {24'h0, ncn[i]});
      wr(4'h7, {24'h0, nop[i]});
      waitIrq(1'b1);
      rdc(4'h7, i < 3 ? 32'h51 : 32'h50);
      rdc(4'h1, i < 3 ? 32'h04 : 32'h00);
      rdc(4'h8, {24'h0, nbk[i]});
    end
    xfer(8'hC5, 8'h06, 6, 4, 256, LBA_TF, LBA, 99, 2'h2);
    xfer(8'hCD, 8'h02, 2, 4, 256, LBA_TF, LBA, 99, 2'h0);
    failAddr <= LBA + 28'h2;
    xfer(8'hC5, 8'h08, 8, 4, 256, LBA_TF, LBA, 2, 2'h2);
    failAddr <= LBA + 28'h1;
    xfer(8'h30, 8'h03, 3, 1, 256, LBA_TF, LBA, 1, 2'h2);
    xfer(8'h31, 8'h00, 256, 1, 256, LBA_TF, LBA, 1, 2'h2);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- tb/awce_flash_model.sv
// Purpose: Flash back end that programs one buffered sector per start.
// Assumes: Buffer read data one cycle after address.
// Notes: Fails the sector at failAddr; lat sets prompt or slow answers.
`timescale 1ns/1ps
`default_nettype none
module awce_flash_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic progStart,
  input wire logic [27:0] progAddr,
  input wire logic [15:0] bufRdData,
  input wire logic [27:0] failAddr,
  input wire logic [7:0] lat,
  output logic [7:0] bufRdAddr,
  output logic progDone,
  output logic progErr,
  output logic [15:0] lastWord,
  output int nStarts
);
  // ==========================================================
  // Sector fetch and program
  logic run_reg;
  logic [9:0] cnt_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= 1'b0;
      cnt_reg <= 10'h000;
      bufRdAddr <= 8'h00;
      progDone <= 1'b0;
      progErr <= 1'b0;
      lastWord <= 16'h0000;
      nStarts <= 0;
    end else begin
      progDone <= 1'b0;
      // Unqualified error line toggles so a stray sample shows
      progErr <= cnt_reg[0];
      bufRdAddr <= cnt_reg[7:0];
      cnt_reg <= progStart ? 10'h000 : cnt_reg + 10'h001;
      if (progStart) begin
        run_reg <= 1'b1;
        nStarts <= nStarts + 1;
      end else if (run_reg && cnt_reg == 10'h101) begin
        lastWord <= bufRdData;
      end else if (run_reg && cnt_reg == 10'h101 + {2'b00, lat}) begin
        run_reg <= 1'b0;
        progDone <= 1'b1;
        progErr <= progAddr == failAddr;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/awce_props.sv
// Purpose: Port assertions for the write engine.
// Assumes: One clock, rstn asynchronous active low.
// Notes: Bound into the engine top below.
`timescale 1ns/1ps
`default_nettype none
module awce_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic intrq,
  input wire logic progStart,
  input wire logic [27:0] progAddr,
  input wire logic progErase,
  input wire logic progVerify,
  input wire logic progDone,
  input wire logic progErr
);
  // ==========================================================
  // Helpers
  logic progBusy_reg;
  logic quiet_reg;
  wire logic cmdDone = avs_write && !avs_waitrequest && avs_address == 4'h7;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      progBusy_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else begin
      progBusy_reg <= progStart | (progBusy_reg & ~progDone);
      // Window from a sector-write command to its first program
      quiet_reg <= cmdDone ? avs_writedata[7:0] inside {8'h30, 8'h31, 8'h38, 8'h3C}
        : quiet_reg & ~progStart;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_wait_cause: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("waitrequest low with no request");
  chk_rdata_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_one_prog: assert property (progBusy_reg |-> !progStart)
    else $error("program start while programming");
  chk_addr_hold: assert property (!progStart |-> $stable(progAddr))
    else $error("program address moved between starts");
  chk_mode_hold: assert property (progBusy_reg |-> $stable(progErase) && $stable(progVerify))
    else $error("erase or verify changed while programming");
  chk_first_quiet: assert property (quiet_reg |-> !intrq)
    else $error("interrupt before first buffer fill");
  chk_start_cause: assert property ($rose(progStart) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("program start without data write");
  cover property (progDone && progErr);
  cover property (progStart && progVerify);
  cover property ($rose(intrq));
endmodule
bind awce_write_engine awce_props u_props (.clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .intrq, .progStart, .progAddr, .progErase,
  .progVerify, .progDone, .progErr);
`default_nettype wire
